//--- include/ecl_pkg.sv
package ecl_pkg;
  // Timing.
  localparam int CLK_MHZ = 250;
  localparam int TMO_MS = 30;
  localparam int TMO_CYC = TMO_MS * CLK_MHZ * 1000;
  // Register offsets on the bus.
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_HWCFG = 8'h08;
  localparam logic [7:0] OFS_RSTCTL = 8'h0C;
  localparam logic [7:0] OFS_MACL = 8'h10;
  localparam logic [7:0] OFS_MACH = 8'h14;
  localparam logic [7:0] OFS_STRAP = 8'h18;
  // Field positions.
  localparam int CMD_BUSY = 31;
  localparam int CMD_OP = 28;
  localparam int CMD_OVF = 17;
  localparam int CMD_TMO = 16;
  localparam int HWCFG_READY = 0;
  localparam int RSTCTL_DIG = 0;
  localparam int AN_RESTART = 9;
  // Command codes.
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE_DISABLE_CMD = 3'h1;
  localparam logic [2:0] OP_WRITE_ENABLE_CMD = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_WRITE_ALL_CMD = 3'h4;
  localparam logic [2:0] OP_ERASE = 3'h5;
  localparam logic [2:0] OP_ERASE_ALL_CMD = 3'h6;
  localparam logic [2:0] OP_RELOAD = 3'h7;
  // Image layout.
  localparam logic [7:0] VALID_FLAG = 8'hA5;
  localparam logic [10:0] IMG_VALID = 11'h000;
  localparam logic [10:0] IMG_MAC_HIGH = 11'h005;
  localparam logic [10:0] IMG_STRAP_FLAG = 11'h007;
  localparam logic [10:0] IMG_STRAP_LAST = 11'h00B;
  localparam logic [10:0] IMG_BURST_FLAG = 11'h00C;
  localparam logic [10:0] EE_LIMIT_S0 = 11'h07F;
  localparam logic [10:0] EE_LIMIT_S1 = 11'h1FF;
  localparam logic [10:0] EE_LIMIT_S2 = 11'h7FF;
  localparam logic [2:0] PH_ADDR = 3'h0;
  localparam logic [2:0] PH_COUNT = 3'h1;
  localparam logic [2:0] PH_DATA0 = 3'h2;
  localparam logic [2:0] PH_DATA3 = 3'h5;
  // Synchronised register addresses.
  localparam logic [3:0] SYNC_LAST = 4'hC;
  localparam logic [9:0] SA_P1 = 10'h100;
  localparam logic [9:0] SA_P2 = 10'h140;
  localparam logic [9:0] SA_VPHY = 10'h180;
  localparam logic [9:0] SA_BASIC = 10'h000;
  localparam logic [9:0] SA_ADV = 10'h010;
  localparam logic [9:0] SA_SPEC = 10'h024;
  localparam logic [9:0] SA_LED = 10'h1BC;
  localparam logic [9:0] SA_FC1 = 10'h1A0;
  localparam logic [9:0] SA_FC2 = 10'h1A4;
  localparam logic [9:0] SA_FCMII = 10'h1A8;

  typedef struct packed {
    logic valid;
    logic seq;
    logic [2:0] op;
    logic [10:0] addr;
    logic [7:0] wdata;
  } ecl_ee_req_t;

  typedef struct packed {
    logic en;
    logic [9:0] addr;
    logic [31:0] data;
  } ecl_reg_wr_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_BOOT = 6'b000010,
    S_LD_NEXT = 6'b000100,
    S_EE_REQ = 6'b001000,
    S_EE_RDY = 6'b010000,
    S_REG_WAIT = 6'b100000
  } ecl_fsm_t;

  typedef struct packed {
    ecl_fsm_t fsm;
    logic ack;
    logic [31:0] rdat;
    ecl_ee_req_t req;
    ecl_reg_wr_t wr;
    logic busy;
    logic tmo;
    logic ovf;
    logic ready;
    logic ld;
    logic strap_ok;
    logic in_sync;
    logic sync_end;
    logic burst;
    logic [2:0] op;
    logic [10:0] addr;
    logic [7:0] data;
    logic [31:0] macl;
    logic [15:0] mach;
    logic [31:0] straps;
    logic [10:0] ptr;
    logic [3:0] sidx;
    logic [7:0] nburst;
    logic [7:0] bcnt;
    logic [7:0] waddr;
    logic [2:0] phase;
    logic [31:0] word;
  } ecl_state_t;

  localparam ecl_state_t ST_RESET = '{fsm: S_BOOT, busy: 1'b1, default: '0};
endpackage

//--- rtl/ecl_timer.sv
`timescale 1ns/10ps
module ecl_timer #(
  parameter int CYCLES = ecl_pkg::TMO_CYC
) (
  // Clock, enable and reset
  input wire logic clk,
  input wire logic ce,
  input wire logic rst,
  // Control and result
  input wire logic run,
  output logic expired
);
  localparam int W = $clog2(CYCLES + 1);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic expired;
  } ecl_tmr_t;
  ecl_tmr_t st;
  ecl_tmr_t next_st;

  // The count restarts whenever the wait is left.
  always_comb begin
    next_st = st;
    if (!run) begin
      next_st = '0;
    end else if (st.cnt == W'(CYCLES - 1)) begin
      next_st.expired = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign expired = st.expired;
endmodule

//--- rtl/ecl_sync_table.sv
`timescale 1ns/10ps
module ecl_sync_table (
  // Selection
  input wire logic [3:0] idx,
  input wire logic [31:0] straps,
  // Register address and value
  output logic [9:0] addr,
  output logic [31:0] data
);
  logic [7:0] p1;
  logic [7:0] p2;
  logic [7:0] mii;
  logic [7:0] b;
  logic [9:0] base;

  assign p1 = straps[7:0];
  assign p2 = straps[15:8];
  assign mii = straps[23:16];

  // Rows 0 to 8 are advert, special and basic of port 1, port 2, virtual.
  always_comb begin
    b = (idx < 4'h3) ? p1 : p2;
    base = (idx < 4'h3) ? ecl_pkg::SA_P1 :
           (idx < 4'h6) ? ecl_pkg::SA_P2 : ecl_pkg::SA_VPHY;
    addr = base;
    data = '0;
    unique case (idx)
      4'h0, 4'h3: begin
        addr = base + ecl_pkg::SA_ADV;
        data = {22'h0, b[6], b[0] ? 4'hF : {b[2] & b[1], b[2] & ~b[1],
                ~b[2] & b[1], ~b[2] & ~b[1]}, 5'h01};
      end
      4'h1, 4'h4: begin
        addr = base + ecl_pkg::SA_SPEC;
        data = {26'h0, b[0], b[2], b[1], 3'h0};
      end
      4'h2, 4'h5: begin
        addr = base + ecl_pkg::SA_BASIC;
        data = {18'h0, b[2], b[0], 2'h0, 1'b1, b[1], 8'h00}; // R18
      end
      4'h6: begin
        addr = base + ecl_pkg::SA_ADV;
        data = {22'h0, mii[4], 4'hF, 5'h01};
      end
      4'h7: begin
        addr = base + ecl_pkg::SA_SPEC;
        data = {24'h0, mii[2], mii[1], mii[0], 5'h00};
      end
      4'h8: begin
        addr = base + ecl_pkg::SA_BASIC;
        data = {18'h0, mii[2], 1'b1, 2'h0, 1'b1, mii[1], 8'h00}; // R20
      end
      4'h9: begin
        addr = ecl_pkg::SA_LED;
        data = {22'h0, mii[7:6], straps[31:24]};
      end
      4'hA: begin
        addr = ecl_pkg::SA_FC1;
        data = {29'h0, p1[7:5]};
      end
      4'hB: begin
        addr = ecl_pkg::SA_FC2;
        data = {29'h0, p2[7:5]};
      end
      default: begin
        addr = ecl_pkg::SA_FCMII;
        data = {29'h0, mii[5:3]};
      end
    endcase
  end
endmodule

//--- rtl/ecl_loader.sv
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
// What this block does
// R1: Erase location; timeout flag after 30 ms.
// R2: Erase all; timeout flag after 30 ms.
// R3: EEPROM ignores erase/write after write-disable.
// R4: EEPROM powers up with erase/write disabled.
// R5: Read command puts byte in data register.
// R6: Write command programs data byte; 30 ms timeout.
// R7: Write-all programs every byte; 30 ms timeout.
// R8: Loader runs after resets and reload command.
// R9: Loader sets busy and clears device ready.
// R10: Host avoids register writes while not ready.
// R11: Byte 0 not A5h: sync PHYs, stop.
// R12: Later image bytes read as sequential burst.
// R13: Bytes 1 to 6 fill MAC address.
// R14: Byte 7 A5h: bytes 8-11 become straps.
// R15: Otherwise read and discard, still sync PHYs.
// R16: Strap bytes map port, MII, LED fields.
// R17: Rewrite each port PHY advert, special, basic.
// R18: Port PHY basic write sets autonegotiation restart.
// R19: Rewrite virtual PHY advert, special, basic.
// R20: Virtual PHY basic write sets autonegotiation restart.
// R21: Reload LED and three flow-control registers.
// R22: Byte 12 burst flag, byte 13 burst count.
// R23: No bursts or last burst: idle, clear busy.
// R24: Burst header address and count, data MSB first.
// R25: Wait for CSR and PMI idle first.
// R26: Stop with overflow flag past size limit.
// R27: Busy until done; no commands while busy.
// R28: Image sections handled strictly in address order.
module ecl_loader #(
  parameter int TMO_CYCLES = ecl_pkg::TMO_CYC
) (
  // Clock, enable and reset
  input wire logic CLOCK,
  input wire logic CE,
  input wire logic RST,
  // Wishbone slave
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  // EEPROM engine link
  output ecl_pkg::ecl_ee_req_t EE_REQ,
  input wire logic EE_DONE,
  input wire logic [7:0] EE_RDATA,
  input wire logic EE_RDY,
  // Straps
  input wire logic [31:0] STRAP_PINS,
  input wire logic [1:0] EE_SIZE,
  output logic [31:0] STRAP_OUT,
  // System register write port
  output ecl_pkg::ecl_reg_wr_t REG_WR,
  input wire logic CSR_BUSY,
  input wire logic PMI_BUSY,
  // Status
  output logic HW_READY,
  output logic [47:0] MAC_ADDR
);
  ecl_pkg::ecl_state_t st;
  ecl_pkg::ecl_state_t next_st;
  logic tmr_exp;
  logic [9:0] tbl_addr;
  logic [31:0] tbl_data;
  logic [10:0] limit;
  logic wb_req;
  logic cmd_go;
  logic dig_go;
  logic [31:0] cmd_rd;

  ecl_timer #(
    .CYCLES(TMO_CYCLES)
  ) u_timer (
    .clk(CLOCK),
    .ce(CE),
    .rst(RST),
    .run(st.fsm == ecl_pkg::S_EE_RDY),
    .expired(tmr_exp)
  );

  ecl_sync_table u_table (
    .idx(st.sidx),
    .straps(st.straps),
    .addr(tbl_addr),
    .data(tbl_data)
  );

  always_comb begin
    unique case (EE_SIZE)
      2'b00: limit = ecl_pkg::EE_LIMIT_S0;
      2'b01: limit = ecl_pkg::EE_LIMIT_S1;
      default: limit = ecl_pkg::EE_LIMIT_S2;
    endcase
  end

  assign cmd_rd = {st.busy, st.op, 10'h000, st.ovf, st.tmo, 5'h00,
                   st.addr};

  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.wr.en = 1'b0;
    wb_req = WB_CYC && WB_STB && !st.ack;
    cmd_go = 1'b0;
    dig_go = 1'b0;
    // Bus slave: one wait state, unmapped reads give zero.
    if (wb_req) begin
      next_st.ack = 1'b1;
      unique case (WB_ADR)
        ecl_pkg::OFS_CMD: next_st.rdat = cmd_rd;
        ecl_pkg::OFS_DATA: next_st.rdat = {24'h0, st.data};
        ecl_pkg::OFS_HWCFG: next_st.rdat = {31'h0, st.ready};
        ecl_pkg::OFS_MACL: next_st.rdat = st.macl;
        ecl_pkg::OFS_MACH: next_st.rdat = {16'h0, st.mach};
        ecl_pkg::OFS_STRAP: next_st.rdat = st.straps;
        default: next_st.rdat = '0;
      endcase
      if (WB_WE) begin
        unique case (WB_ADR)
          ecl_pkg::OFS_CMD: begin
            if (WB_SEL[2] && WB_DAT_I[ecl_pkg::CMD_TMO]) begin
              next_st.tmo = 1'b0;
            end
            if (WB_SEL[2] && WB_DAT_I[ecl_pkg::CMD_OVF]) begin
              next_st.ovf = 1'b0;
            end
            cmd_go = (WB_SEL == 4'hF) && WB_DAT_I[ecl_pkg::CMD_BUSY] &&
                     !st.busy; // R27
          end
          ecl_pkg::OFS_DATA: begin
            if (!st.busy && WB_SEL[0]) begin
              next_st.data = WB_DAT_I[7:0];
            end
          end
          ecl_pkg::OFS_RSTCTL: begin
            dig_go = !st.busy && WB_SEL[0] &&
                     WB_DAT_I[ecl_pkg::RSTCTL_DIG];
          end
          default: begin
          end
        endcase
      end
    end
    // Command issue.
    if (cmd_go) begin
      next_st.op = WB_DAT_I[ecl_pkg::CMD_OP +: 3];
      next_st.addr = WB_DAT_I[10:0];
      next_st.busy = 1'b1; // R27
      if (WB_DAT_I[ecl_pkg::CMD_OP +: 3] == ecl_pkg::OP_RELOAD) begin
        next_st.ld = 1'b1; // R8
        next_st.ready = 1'b0; // R9
        next_st.ptr = ecl_pkg::IMG_VALID;
        next_st.burst = 1'b0;
        next_st.req.seq = 1'b0;
        next_st.fsm = ecl_pkg::S_LD_NEXT;
      end else begin
        next_st.req.valid = 1'b1;
        next_st.req.seq = 1'b0;
        next_st.req.op = WB_DAT_I[ecl_pkg::CMD_OP +: 3];
        next_st.req.addr = WB_DAT_I[10:0];
        next_st.req.wdata = st.data; // R6 R7
        next_st.fsm = ecl_pkg::S_EE_REQ;
      end
    end
    if (dig_go) begin
      next_st.busy = 1'b1;
      next_st.ready = 1'b0;
      next_st.fsm = ecl_pkg::S_BOOT; // R8
    end
    unique case (st.fsm)
      ecl_pkg::S_IDLE: begin
      end
      ecl_pkg::S_BOOT: begin
        next_st.straps = STRAP_PINS;
        next_st.ld = 1'b1;
        next_st.busy = 1'b1; // R9
        next_st.ready = 1'b0; // R9
        next_st.burst = 1'b0;
        next_st.req.seq = 1'b0;
        next_st.ptr = ecl_pkg::IMG_VALID;
        next_st.fsm = ecl_pkg::S_LD_NEXT;
      end
      ecl_pkg::S_LD_NEXT: begin
        // A pointer back at zero after sequential reads has wrapped.
        if (st.ptr > limit ||
            (st.ptr == ecl_pkg::IMG_VALID && st.req.seq)) begin
          next_st.ovf = 1'b1; // R26
          next_st.ld = 1'b0;
          next_st.busy = 1'b0;
          next_st.ready = 1'b1;
          next_st.fsm = ecl_pkg::S_IDLE;
        end else begin
          next_st.req.valid = 1'b1;
          next_st.req.seq = (st.ptr != ecl_pkg::IMG_VALID); // R12
          next_st.req.op = ecl_pkg::OP_READ;
          next_st.req.addr = st.ptr;
          next_st.req.wdata = 8'h00;
          next_st.fsm = ecl_pkg::S_EE_REQ;
        end
      end
      ecl_pkg::S_EE_REQ: begin
        if (EE_DONE) begin
          next_st.req.valid = 1'b0;
          if (st.ld) begin
            // Image bytes are taken in address order.
            next_st.ptr = st.ptr + 11'h001; // R28
            next_st.fsm = ecl_pkg::S_LD_NEXT;
            if (!st.burst) begin
              if (st.ptr == ecl_pkg::IMG_VALID) begin
                if (EE_RDATA != ecl_pkg::VALID_FLAG) begin
                  next_st.in_sync = 1'b1; // R11
                  next_st.sync_end = 1'b1;
                  next_st.sidx = '0;
                  next_st.fsm = ecl_pkg::S_REG_WAIT;
                end
              end else if (st.ptr < ecl_pkg::IMG_MAC_HIGH) begin
                next_st.macl = {EE_RDATA, st.macl[31:8]}; // R13
              end else if (st.ptr < ecl_pkg::IMG_STRAP_FLAG) begin
                next_st.mach = {EE_RDATA, st.mach[15:8]}; // R13
              end else if (st.ptr == ecl_pkg::IMG_STRAP_FLAG) begin
                next_st.strap_ok = (EE_RDATA == ecl_pkg::VALID_FLAG);
              end else if (st.ptr <= ecl_pkg::IMG_STRAP_LAST) begin
                if (st.strap_ok) begin
                  next_st.straps = {EE_RDATA, st.straps[31:8]}; // R14 R16
                end
                if (st.ptr == ecl_pkg::IMG_STRAP_LAST) begin
                  next_st.in_sync = 1'b1; // R15 R17 R19 R21
                  next_st.sync_end = 1'b0;
                  next_st.sidx = '0;
                  next_st.fsm = ecl_pkg::S_REG_WAIT;
                end
              end else if (st.ptr == ecl_pkg::IMG_BURST_FLAG) begin
                if (EE_RDATA != ecl_pkg::VALID_FLAG) begin
                  next_st.ld = 1'b0; // R22 R23
                  next_st.busy = 1'b0;
                  next_st.ready = 1'b1;
                  next_st.fsm = ecl_pkg::S_IDLE;
                end
              end else begin
                next_st.nburst = EE_RDATA; // R22
                next_st.burst = 1'b1;
                next_st.phase = ecl_pkg::PH_ADDR;
                if (EE_RDATA == 8'h00) begin
                  next_st.ld = 1'b0; // R23
                  next_st.busy = 1'b0;
                  next_st.ready = 1'b1;
                  next_st.fsm = ecl_pkg::S_IDLE;
                end
              end
            end else begin
              unique case (st.phase)
                ecl_pkg::PH_ADDR: begin
                  next_st.waddr = EE_RDATA; // R24
                  next_st.phase = ecl_pkg::PH_COUNT;
                end
                ecl_pkg::PH_COUNT: begin
                  next_st.bcnt = EE_RDATA; // R24
                  next_st.phase = ecl_pkg::PH_DATA0;
                  if (EE_RDATA == 8'h00) begin
                    next_st.nburst = st.nburst - 8'h01;
                    next_st.phase = ecl_pkg::PH_ADDR;
                    if (st.nburst == 8'h01) begin
                      next_st.ld = 1'b0; // R23
                      next_st.busy = 1'b0;
                      next_st.ready = 1'b1;
                      next_st.fsm = ecl_pkg::S_IDLE;
                    end
                  end
                end
                default: begin
                  next_st.word = {st.word[23:0], EE_RDATA}; // R24
                  next_st.phase = st.phase + 3'h1;
                  if (st.phase == ecl_pkg::PH_DATA3) begin
                    next_st.fsm = ecl_pkg::S_REG_WAIT;
                  end
                end
              endcase
            end
          end else if (st.op == ecl_pkg::OP_READ) begin
            next_st.data = EE_RDATA; // R5
            next_st.busy = 1'b0;
            next_st.fsm = ecl_pkg::S_IDLE;
          end else if (st.op == ecl_pkg::OP_WRITE_DISABLE_CMD ||
                       st.op == ecl_pkg::OP_WRITE_ENABLE_CMD) begin
            next_st.busy = 1'b0;
            next_st.fsm = ecl_pkg::S_IDLE;
          end else begin
            next_st.fsm = ecl_pkg::S_EE_RDY;
          end
        end
      end
      ecl_pkg::S_EE_RDY: begin
        if (EE_RDY) begin
          next_st.busy = 1'b0; // R27
          next_st.fsm = ecl_pkg::S_IDLE;
        end else if (tmr_exp) begin
          next_st.tmo = 1'b1; // R1 R2 R6 R7
          next_st.busy = 1'b0;
          next_st.fsm = ecl_pkg::S_IDLE;
        end
      end
      ecl_pkg::S_REG_WAIT: begin
        if (!CSR_BUSY && !PMI_BUSY) begin
          next_st.wr.en = 1'b1; // R25
          next_st.fsm = ecl_pkg::S_LD_NEXT;
          if (st.in_sync) begin
            next_st.wr.addr = tbl_addr; // R17 R19 R21
            next_st.wr.data = tbl_data;
            next_st.sidx = st.sidx + 4'h1;
            if (st.sidx == ecl_pkg::SYNC_LAST) begin
              next_st.in_sync = 1'b0;
              if (st.sync_end) begin
                next_st.ld = 1'b0; // R11
                next_st.busy = 1'b0;
                next_st.ready = 1'b1;
                next_st.fsm = ecl_pkg::S_IDLE;
              end
            end else begin
              next_st.fsm = ecl_pkg::S_REG_WAIT;
            end
          end else begin
            next_st.wr.addr = {st.waddr, 2'b00}; // R24
            next_st.wr.data = st.word;
            next_st.waddr = st.waddr + 8'h01;
            next_st.bcnt = st.bcnt - 8'h01;
            next_st.phase = ecl_pkg::PH_DATA0;
            if (st.bcnt == 8'h01) begin
              next_st.nburst = st.nburst - 8'h01;
              next_st.phase = ecl_pkg::PH_ADDR;
              if (st.nburst == 8'h01) begin
                next_st.ld = 1'b0; // R23
                next_st.busy = 1'b0;
                next_st.ready = 1'b1;
                next_st.fsm = ecl_pkg::S_IDLE;
              end
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st <= ecl_pkg::ST_RESET;
    end else if (CE) begin
      st <= next_st;
    end
  end

  assign WB_ACK = st.ack;
  assign WB_DAT_O = st.rdat;
  assign EE_REQ = st.req;
  assign REG_WR = st.wr;
  assign HW_READY = st.ready;
  assign STRAP_OUT = st.straps;
  assign MAC_ADDR = {st.mach, st.macl};

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  a_ack_one_cycle: assert property (WB_ACK |=> !WB_ACK)
    else $error("ack held longer than one cycle");
  a_ack_after_req: assert property (
    (WB_CYC && WB_STB && !WB_ACK && CE) |=> WB_ACK)
    else $error("request not answered next cycle");
  a_loader_not_ready: assert property ( // R9
    (st.ld && st.fsm != ecl_pkg::S_BOOT) |-> (st.busy && !HW_READY))
    else $error("ready or idle while loader runs");
  a_cmd_sets_busy: assert property ( // R27
    cmd_go && CE |=> st.busy ##0 (st.fsm != ecl_pkg::S_IDLE))
    else $error("accepted command did not set busy");
  a_timeout_flag: assert property ( // R1
    (st.fsm == ecl_pkg::S_EE_RDY && tmr_exp && !EE_RDY && CE)
    |=> (st.tmo && !st.busy))
    else $error("timeout did not set flag");
  a_read_data: assert property ( // R5
    (st.fsm == ecl_pkg::S_EE_REQ && !st.ld && st.op == ecl_pkg::OP_READ
     && EE_DONE && CE) |=> (st.data == $past(EE_RDATA)))
    else $error("read byte not captured");
  a_write_waits: assert property ( // R25
    REG_WR.en |-> (!$past(CSR_BUSY) && !$past(PMI_BUSY)))
    else $error("register write while interface busy");
  a_basic_restart: assert property ( // R18
    (REG_WR.en && REG_WR.addr == ecl_pkg::SA_P1 + ecl_pkg::SA_BASIC)
    |-> REG_WR.data[ecl_pkg::AN_RESTART])
    else $error("basic control written without restart");
  a_bad_image: assert property ( // R11
    (st.fsm == ecl_pkg::S_EE_REQ && st.ld && !st.burst &&
     st.ptr == ecl_pkg::IMG_VALID && EE_DONE && CE &&
     EE_RDATA != ecl_pkg::VALID_FLAG) |=> (st.in_sync && st.sync_end))
    else $error("invalid image did not go to strap sync");
  a_overflow_stop: assert property ( // R26
    (st.fsm == ecl_pkg::S_LD_NEXT && st.ptr > limit && CE)
    |=> (st.ovf && !EE_REQ.valid && HW_READY))
    else $error("overflow not flagged");
endmodule

//--- test/ecl_ee_model.sv
`timescale 1ns/10ps
module ecl_ee_model (
  // Link from the controller
  input wire logic clk,
  input ecl_pkg::ecl_ee_req_t req,
  input wire logic hang,
  // Answer
  output logic done,
  output logic [7:0] rdata,
  output logic rdy
);
  logic [7:0] mem [0:2047];
  logic wen = 1'b0;
  logic [10:0] last = '0;
  int wt = 0;
  int bz = 0;
  initial begin
    done = 1'b0;
    rdata = 8'h00;
    rdy = 1'b1;
  end
  // The data line toggles while released, so stale data never matches.
  always @(posedge clk) begin
    logic [10:0] a;
    logic er;
    logic al;
    a = req.seq ? last + 11'h001 : req.addr;
    er = req.op inside {ecl_pkg::OP_ERASE, ecl_pkg::OP_ERASE_ALL_CMD};
    al = req.op inside {ecl_pkg::OP_WRITE_ALL_CMD, ecl_pkg::OP_ERASE_ALL_CMD};
    done <= 1'b0;
    rdata <= ~rdata;
    rdy <= (bz == 0) && !hang;
    if (bz > 0) bz <= bz - 1;
    if (req.valid && !done) begin
      wt <= wt + 1;
      if (wt >= 2 + int'(a[0])) begin
        wt <= 0;
        done <= 1'b1;
        last <= a;
        case (req.op)
          ecl_pkg::OP_READ: rdata <= mem[a];
          ecl_pkg::OP_WRITE_DISABLE_CMD: wen <= 1'b0;
          ecl_pkg::OP_WRITE_ENABLE_CMD: wen <= 1'b1;
          default: begin
            bz <= 6;
            rdy <= 1'b0;
            for (int i = 0; i < 2048; i++) begin
              if (wen && (al || i == a)) mem[i] <= er ? 8'hFF : req.wdata;
            end
          end
        endcase
      end
    end
  end
endmodule

//--- test/tb_ecl_loader.sv
`timescale 1ns/10ps
module tb_ecl_loader;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, hang = 1'b0;
  logic csr = 1'b0, pmi = 1'b0, pbusy = 1'b0, chk = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, straps = 32'h0, rd, dout, sout;
  logic [1:0] esz = 2'h2;
  logic ack, done, rdy, ready;
  logic [7:0] erd;
  logic [47:0] mac;
  ecl_pkg::ecl_ee_req_t req;
  ecl_pkg::ecl_reg_wr_t wr;
  logic [63:0] q [$];
  int n_errors = 0;
  int checks = 0;
  int nwr = 0;
  always #2 clock = ~clock;
  ecl_loader #(.TMO_CYCLES(50)) i_dut (.CLOCK(clock), .CE(1'b1),
    .RST(rst), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we), .WB_ADR(adr),
    .WB_SEL(4'hF), .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK(ack),
    .EE_REQ(req), .EE_DONE(done), .EE_RDATA(erd), .EE_RDY(rdy),
    .STRAP_PINS(straps), .EE_SIZE(esz), .STRAP_OUT(sout), .REG_WR(wr),
    .CSR_BUSY(csr), .PMI_BUSY(pmi), .HW_READY(ready), .MAC_ADDR(mac));
  ecl_ee_model i_ee (.clk(clock), .req(req), .hang(hang), .done(done),
    .rdata(erd), .rdy(rdy));
  task automatic cmp(input string n, input logic [31:0] e, s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Random stalls of the register fabric; the oldest note is compared.
  always @(posedge clock) begin
    logic [63:0] e;
    csr <= ($urandom % 4) == 0;
    pmi <= ($urandom % 4) == 0;
    pbusy <= csr | pmi;
    if (ack === 1'b1 && chk === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      cmp("reg", e[31:0], dout & e[63:32]);
    end
    if (wr.en === 1'b1) begin
      nwr++;
      cmp("busy", 32'h0, {31'h0, pbusy});
      if (wr.addr[5:0] === 6'h00 && wr.addr[9:8] === 2'h1)
        cmp("restart", 32'h1, {31'h0, wr.data[9]});
      if (wr.addr === 10'h040) begin
        cmp("burst", 32'h11223344, wr.data);
        cmp("order", 32'd14, nwr);
      end
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clock); while (ack !== 1'b1);
    rd = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
    q.push_back({m, e});
    chk <= 1'b1;
    wb(1'b0, a, 32'h0);
    chk <= 1'b0;
  endtask
  task automatic idle;
    repeat (500) begin
      wb(1'b0, ecl_pkg::OFS_CMD, 32'h0);
      if (rd[31] === 1'b0) break;
    end
    cmp("idle", 32'h0, {31'h0, rd[31]});
  endtask
  task automatic go(input logic [2:0] op, input logic [10:0] a);
    wb(1'b1, ecl_pkg::OFS_CMD, {1'b1, op, 17'h0, a});
    idle;
  endtask
  initial begin
    logic [10:0] a;
    logic [7:0] d;
    void'($urandom(67375));
    straps = $urandom;
    for (int i = 0; i < 2048; i++) i_ee.mem[i] = 8'($urandom);
    i_ee.mem[0] = 8'hA5;
    i_ee.mem[7] = 8'hA5;
    i_ee.mem[12] = 8'hA5;
    i_ee.mem[13] = 8'h01;
    i_ee.mem[14] = 8'h10;
    i_ee.mem[15] = 8'h01;
    for (int i = 0; i < 4; i++) i_ee.mem[16 + i] = 8'(8'h11 * (i + 1));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    idle;
    cmp("syncs", 32'd14, nwr);
    cmp("ready", 32'h1, {31'h0, ready});
    cmp("mach", 32'({i_ee.mem[6], i_ee.mem[5]}), 32'(mac[47:32]));
    rc(ecl_pkg::OFS_MACL, 32'hFFFFFFFF, {i_ee.mem[4], i_ee.mem[3],
      i_ee.mem[2], i_ee.mem[1]});
    rc(ecl_pkg::OFS_MACH, 32'hFFFF, {16'h0, i_ee.mem[6], i_ee.mem[5]});
    rc(ecl_pkg::OFS_STRAP, 32'hFFFFFFFF, {i_ee.mem[11], i_ee.mem[10],
      i_ee.mem[9], i_ee.mem[8]});
    rc(ecl_pkg::OFS_HWCFG, 32'h1, 32'h1);
    for (int k = 0; k < 3; k++) begin
      a = 11'h100 + 11'($urandom % 1024);
      d = 8'($urandom);
      go(ecl_pkg::OP_READ, a);
      rc(ecl_pkg::OFS_DATA, 32'hFF, {24'h0, i_ee.mem[a]});
      go(ecl_pkg::OP_WRITE_ENABLE_CMD, 11'h0);
      wb(1'b1, ecl_pkg::OFS_DATA, {24'h0, d});
      go(ecl_pkg::OP_WRITE, a);
      go(ecl_pkg::OP_READ, a);
      rc(ecl_pkg::OFS_DATA, 32'hFF, {24'h0, d});
      go(ecl_pkg::OP_WRITE_DISABLE_CMD, 11'h0);
      wb(1'b1, ecl_pkg::OFS_DATA, {24'h0, ~d});
      go(ecl_pkg::OP_WRITE, a);
      go(ecl_pkg::OP_READ, a);
      rc(ecl_pkg::OFS_DATA, 32'hFF, {24'h0, d});
    end
    nwr = 0;
    wb(1'b1, ecl_pkg::OFS_CMD, {1'b1, ecl_pkg::OP_RELOAD, 28'h0});
    rc(ecl_pkg::OFS_HWCFG, 32'h1, 32'h0);
    rc(ecl_pkg::OFS_CMD, 32'h80000000, 32'h80000000);
    idle;
    cmp("reload", 32'd14, nwr);
    esz <= 2'h0;
    i_ee.mem[14] = 8'h20;
    i_ee.mem[15] = 8'hFF;
    go(ecl_pkg::OP_RELOAD, 11'h0);
    rc(ecl_pkg::OFS_CMD, 32'h20000, 32'h20000);
    rc(ecl_pkg::OFS_HWCFG, 32'h1, 32'h1);
    wb(1'b1, ecl_pkg::OFS_CMD, 32'h20000);
    rc(ecl_pkg::OFS_CMD, 32'h20000, 32'h0);
    nwr = 0;
    straps <= $urandom;
    i_ee.mem[0] = 8'h00;
    wb(1'b1, ecl_pkg::OFS_RSTCTL, 32'h1);
    idle;
    cmp("bad image", 32'd13, nwr);
    cmp("pins", straps, sout);
    hang <= 1'b1;
    go(ecl_pkg::OP_WRITE_ENABLE_CMD, 11'h0);
    // Codes three to six: write, write-all, erase, erase-all.
    for (int k = 0; k < 4; k++) begin
      go(ecl_pkg::OP_WRITE + 3'(k), a);
      rc(ecl_pkg::OFS_CMD, 32'h10000, 32'h10000);
      wb(1'b1, ecl_pkg::OFS_CMD, 32'h10000);
      rc(ecl_pkg::OFS_CMD, 32'h10000, 32'h0);
    end
    summarize;
  end
  initial begin
    #(4 * 60000);
    n_errors++;
    summarize;
  end
endmodule
